// *** rtl/pin_map_cfg.svh ***
/*
 register offsets, field positions and reset defaults for the enable-pin map
 and power-good register bank; assumes byte-wide registers on an 8-bit index
*/
`ifndef PIN_MAP_CFG_SVH
`define PIN_MAP_CFG_SVH
`define PIN3_MAP_HIGH_OFS 8'h34
`define PIN4_MAP_LOW_OFS 8'h35
`define PIN4_MAP_HIGH_OFS 8'h36
`define STATUS_A_OFS 8'h37
`define STATUS_B_OFS 8'h38
`define MAP_HIGH_MASK 8'h3f
`define MAP_BUCK_MSB 5
`define MAP_BUCK_LSB 2
`define MAP_LINEAR_MSB 1
`define MAP_LINEAR_LSB 0
`define STATUS_B_MASK 8'h3f
`define STATUS_RESET 8'h00
`define SYNC_STAGES 2
`endif

// *** rtl/pin_map_pkg.sv ***
/*
 types shared by the register bank: the register access request and the
 comparator status bundle; assumes nothing beyond the cfg header
*/
package pin_map_pkg;
   typedef struct packed {
      logic wr; // write strobe, one cycle
      logic rd; // read strobe, one cycle
      logic [7:0] addr; // register offset
      logic [7:0] wdata; // write data
   } reg_req_s;

   typedef struct packed {
      logic [3:0] buck_pg; // buck converters 4..1
      logic [9:0] linear_pg; // linear regulators 10..1
   } pg_status_s;
endpackage

// *** rtl/pg_sync.sv ***
/*
 two-flop synchroniser for the fourteen comparator outputs; assumes the
 comparator levels are asynchronous to clock_i
*/
`timescale 1ns/1ns
`default_nettype none
module pg_sync
   import pin_map_pkg::*;
(
   input wire logic clock_i, // system clock
   input wire logic rst_b_i, // synchronous reset, active low
   input wire pg_status_s async_i, // raw comparator levels
   output pg_status_s sync_o // levels in clock domain
);
   typedef struct packed {
      pg_status_s meta;
      pg_status_s stable;
   } sync_state_s;

   sync_state_s state_reg;
   sync_state_s state_next;

   // first stage feeds only the second stage
   always_comb begin
      state_next = state_reg;
      state_next.meta = async_i;
      state_next.stable = state_reg.meta;
      if (!rst_b_i) begin
         state_next = '0;
      end
   end

   always_ff @(posedge clock_i) begin
      state_reg <= state_next;
   end

   assign sync_o = state_reg.stable;
endmodule // pg_sync
`default_nettype wire

// *** rtl/pin_map_regs.sv ***
/*
 enable-pin 3/4 map registers and power-good status registers of the power
 manager: map storage with otp reload, offset decode, read mux, synchronised
 status words, and the pin-control and pin-enable outputs handed on to the
 enable combiner
 assumes a serial-bus front end on clock_i delivers one-cycle read and write
 strobes with offset and data, that otp defaults are valid while reset is
 low, and that comparators and enable pins are asynchronous to clock_i;
 supply-below-threshold filtering of status is left to software
*/
`include "pin_map_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module pin_map_regs
   import pin_map_pkg::*;
(
   input wire logic clock_i, // system clock, 125 MHz
   input wire logic rst_b_i, // synchronous por reset, active low
   input wire reg_req_s req_i, // register access from bus front end
   output logic [7:0] rdata_o, // read data, registered
   output logic rvalid_o, // read data valid pulse
   input wire logic [7:0] otp_pin3_high_i, // otp default, pin3 high map
   input wire logic [7:0] otp_pin4_low_i, // otp default, pin4 low map
   input wire logic [7:0] otp_pin4_high_i, // otp default, pin4 high map
   input wire pg_status_s pg_raw_i, // comparator outputs, async
   input wire logic ext_enable_pin_3_i, // external enable pin 3
   input wire logic ext_enable_pin_4_i, // external enable pin 4
   output logic [9:0] linear_pin_ctrl_o, // regs 10..1 under pin control
   output logic [3:0] buck_pin_ctrl_o, // bucks 4..1 under pin control
   output logic [9:0] linear_pin_en_o, // pin-driven enable, regs 10..1
   output logic [3:0] buck_pin_en_o // pin-driven enable, bucks 4..1
);
   typedef struct packed {
      logic [7:0] pin3_high;
      logic [7:0] pin4_low;
      logic [7:0] pin4_high;
      logic [7:0] rdata;
      logic rvalid;
      logic [1:0] pin3_sync;
      logic [1:0] pin4_sync;
   } regs_state_s;

   // which register an offset selects; one decoder serves both paths
   typedef enum logic [2:0] {
      sel_none,
      sel_pin3_high,
      sel_pin4_low,
      sel_pin4_high,
      sel_status_a,
      sel_status_b
   } reg_id_e;

   regs_state_s state_reg;
   regs_state_s state_next;
   pg_status_s pg_sync;
   logic [7:0] pg_a;
   logic [7:0] pg_b;
   logic [9:0] lin_sel3;
   logic [9:0] lin_sel4;
   logic [3:0] buck_sel3;
   logic [3:0] buck_sel4;
   reg_id_e target;
   logic pin3_level;
   logic pin4_level;

   // high map: bits 7..6 never store a one
   function automatic logic [7:0] high_map(input logic [7:0] val);
      high_map = val & `MAP_HIGH_MASK;
   endfunction

   // offset decode; anything outside the bank falls to sel_none
   function automatic reg_id_e decode_offset(input logic [7:0] addr);
      reg_id_e id;
      if (addr == `PIN3_MAP_HIGH_OFS) begin
         id = sel_pin3_high;
      end else if (addr == `PIN4_MAP_LOW_OFS) begin
         id = sel_pin4_low;
      end else if (addr == `PIN4_MAP_HIGH_OFS) begin
         id = sel_pin4_high;
      end else if (addr == `STATUS_A_OFS) begin
         id = sel_status_a;
      end else if (addr == `STATUS_B_OFS) begin
         id = sel_status_b;
      end else begin
         id = sel_none;
      end
      decode_offset = id;
   endfunction

   // regulator selects: low map gives regs 8..1, high map regs 10..9
   function automatic logic [9:0] linear_select(input logic [7:0] low_map, input logic [7:0] high_map_val);
      linear_select = {high_map_val[`MAP_LINEAR_MSB:`MAP_LINEAR_LSB], low_map};
   endfunction

   // buck selects sit just above the regulator pair in a high map
   function automatic logic [3:0] buck_select(input logic [7:0] high_map_val);
      buck_select = high_map_val[`MAP_BUCK_MSB:`MAP_BUCK_LSB];
   endfunction

   // a pin only reaches the outputs its map hands over
   function automatic logic [9:0] gate_linear(input logic [9:0] sel, input logic pin);
      gate_linear = sel & {10{pin}};
   endfunction

   function automatic logic [3:0] gate_buck(input logic [3:0] sel, input logic pin);
      gate_buck = sel & {4{pin}};
   endfunction

   // status a: regulators 4..1 above bucks 4..1, one bit per comparator
   function automatic logic [7:0] status_a_word(input pg_status_s pg);
      status_a_word = {pg.linear_pg[3:0], pg.buck_pg};
   endfunction

   // status b: regulators 10..5, top two bits always read zero
   function automatic logic [7:0] status_b_word(input pg_status_s pg);
      status_b_word = {2'h0, pg.linear_pg[9:4]} & `STATUS_B_MASK;
   endfunction

   pg_sync u_pg_sync (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .async_i(pg_raw_i),
      .sync_o(pg_sync)
   );

   // status words straight from synchronised comparators, no latching
   assign pg_a = status_a_word(pg_sync);
   assign pg_b = status_b_word(pg_sync);

   // one decode shared by the write and the read path
   assign target = decode_offset(req_i.addr);

   // map fields: low map covers regs 8..1, high map bucks then regs 10..9
   assign lin_sel4 = linear_select(state_reg.pin4_low, state_reg.pin4_high);
   assign buck_sel4 = buck_select(state_reg.pin4_high);
   // pin 3 low map lies outside this bank, so regs 8..1 never follow pin 3
   assign lin_sel3 = linear_select(8'h00, state_reg.pin3_high);
   assign buck_sel3 = buck_select(state_reg.pin3_high);

   // only the second flop of each pin synchroniser feeds logic
   assign pin3_level = state_reg.pin3_sync[1];
   assign pin4_level = state_reg.pin4_sync[1];

   always_comb begin
      state_next = state_reg;
      state_next.rvalid = 1'b0;
      state_next.pin3_sync = {state_reg.pin3_sync[0], ext_enable_pin_3_i};
      state_next.pin4_sync = {state_reg.pin4_sync[0], ext_enable_pin_4_i};
      // writes land only on the map registers; status offsets drop them
      if (req_i.wr) begin
         case (target)
            sel_pin3_high: begin
               state_next.pin3_high = high_map(req_i.wdata);
            end
            sel_pin4_low: begin
               state_next.pin4_low = req_i.wdata;
            end
            sel_pin4_high: begin
               state_next.pin4_high = high_map(req_i.wdata);
            end
            default: begin
               // status and unmapped offsets keep their contents, no error
            end
         endcase
      end
      // read decode; a read beside a write returns the old value
      if (req_i.rd) begin
         state_next.rvalid = 1'b1;
         case (target)
            sel_pin3_high: begin
               state_next.rdata = state_reg.pin3_high;
            end
            sel_pin4_low: begin
               state_next.rdata = state_reg.pin4_low;
            end
            sel_pin4_high: begin
               state_next.rdata = state_reg.pin4_high;
            end
            sel_status_a: begin
               state_next.rdata = pg_a;
            end
            sel_status_b: begin
               state_next.rdata = pg_b;
            end
            default: begin
               state_next.rdata = 8'h00; // unmapped offsets read zero
            end
         endcase
      end
      // por reload from otp; reset wins over any access
      if (!rst_b_i) begin
         state_next = '0;
         state_next.pin3_high = high_map(otp_pin3_high_i);
         state_next.pin4_low = otp_pin4_low_i;
         state_next.pin4_high = high_map(otp_pin4_high_i);
      end
   end

   // otp levels are sampled through the reset branch, clocked, not async
   always_ff @(posedge clock_i) begin
      state_reg <= state_next;
   end

   assign rdata_o = state_reg.rdata;
   assign rvalid_o = state_reg.rvalid;
   // a pin may own an output if either map hands it over
   assign linear_pin_ctrl_o = lin_sel3 | lin_sel4;
   assign buck_pin_ctrl_o = buck_sel3 | buck_sel4;
   // pin-driven enables; combining with register enables lives elsewhere
   assign linear_pin_en_o = gate_linear(lin_sel3, pin3_level)
                          | gate_linear(lin_sel4, pin4_level);
   assign buck_pin_en_o = gate_buck(buck_sel3, pin3_level)
                        | gate_buck(buck_sel4, pin4_level);
endmodule // pin_map_regs
`default_nettype wire

// *** bench/pin_map_regs_properties.sv ***
/* checker for pin_map_regs ports
   assumes one clock, synchronous active-low reset */
`timescale 1ns/1ns
`default_nettype none
module pin_map_regs_chk
   import pin_map_pkg::*;
(
   input wire logic clock_i, // clock
   input wire logic rst_b_i, // reset, low
   input wire reg_req_s req_i, // request
   input wire logic [7:0] rdata_o, // read data
   input wire logic rvalid_o, // read valid
   input wire pg_status_s pg_raw_i, // comparators
   input wire logic [9:0] linear_pin_ctrl_o // pin control
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   // status judged only once the synchroniser has settled
   AST_RVALID: assert property (rvalid_o == $past(req_i.rd))
      else $error("rvalid timing");
   AST_HOLD: assert property (!req_i.rd |=> $stable(rdata_o))
      else $error("rdata moved");
   AST_RESERVED_ZERO: assert property (req_i.rd && (req_i.addr == 8'h34 || req_i.addr == 8'h36) |=> rdata_o[7:6] == 2'b00)
      else $error("reserved bits set");
   // expected word is the comparator level at the read edge, not one later
   AST_PG_A: assert property (req_i.rd && req_i.addr == 8'h37 && $past(rst_b_i, 2) && $stable(pg_raw_i)
      && $past(pg_raw_i, 2) == pg_raw_i |=> rdata_o == {$past(pg_raw_i.linear_pg[3:0]), $past(pg_raw_i.buck_pg)})
      else $error("status a wrong");
   AST_PG_B: assert property (req_i.rd && req_i.addr == 8'h38 && $past(rst_b_i, 2) && $stable(pg_raw_i)
      && $past(pg_raw_i, 2) == pg_raw_i |=> rdata_o == {2'b00, $past(pg_raw_i.linear_pg[9:4])})
      else $error("status b wrong");
   AST_MAP_LOW: assert property (req_i.wr && req_i.addr == 8'h35 |=> linear_pin_ctrl_o[7:0] == $past(req_i.wdata))
      else $error("low map not applied");
   AST_UNMAPPED: assert property (req_i.rd && (req_i.addr < 8'h34 || req_i.addr > 8'h38) |=> rdata_o == 8'h00)
      else $error("unmapped read nonzero");
   AST_RESET: assert property (disable iff (1'b0) !rst_b_i |=> rdata_o == 8'h00 && !rvalid_o)
      else $error("reset values");
   cover property (req_i.wr && req_i.addr == 8'h35);
   cover property (req_i.rd && req_i.addr == 8'h37);
   cover property (req_i.rd && req_i.addr == 8'h38);
endmodule // pin_map_regs_chk
bind pin_map_regs pin_map_regs_chk chk (.clock_i(clock_i), .rst_b_i(rst_b_i), .req_i(req_i), .rdata_o(rdata_o),
   .rvalid_o(rvalid_o), .pg_raw_i(pg_raw_i), .linear_pin_ctrl_o(linear_pin_ctrl_o));
`default_nettype wire

// *** bench/host_model.sv ***
/* host model issuing one-cycle register strobes
   assumes tasks are entered 1 ns after a rising edge */
`timescale 1ns/1ns
`default_nettype none
module host_model
   import pin_map_pkg::*;
(
   input wire logic clock_i, // clock
   input wire logic [7:0] rdata_i, // read data
   input wire logic rvalid_i, // read valid pulse
   output var reg_req_s req_o // request
);
   initial req_o = '0;
   // idle edge after each strobe so strobes never merge
   task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      req_o = reg_req_s'{w, !w, a, d};
      @(posedge clock_i);
      #1;
      q = rvalid_i ? rdata_i : 8'hxx; // only with the valid pulse; supplies held up, status trusted
      req_o = '0;
      @(posedge clock_i);
      #1;
   endtask
endmodule // host_model
`default_nettype wire

// *** bench/tb_pin_map_regs.sv ***
/* bench for pin_map_regs driven through host_model
   assumes inputs change 1 ns after edges */
`timescale 1ns/1ns
`default_nettype none
module tb_pin_map_regs;
   import pin_map_pkg::*;
   logic clock_i = 1'b0, rst_b_i = 1'b0, pin3 = 1'b0, pin4 = 1'b0, rvalid;
   logic [7:0] otp = 8'ha5, rdata;
   pg_status_s pg = '{4'h9, 10'h2c6};
   reg_req_s req;
   logic [9:0] lc, le;
   logic [3:0] bc, be;
   int errors = 0, check_count = 0, cycles = 0;
   initial forever #4 clock_i = ~clock_i;
   host_model host (.clock_i(clock_i), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));
   pin_map_regs uut (.clock_i(clock_i), .rst_b_i(rst_b_i), .req_i(req), .rdata_o(rdata), .rvalid_o(rvalid),
      .otp_pin3_high_i(8'hff), .otp_pin4_low_i(otp), .otp_pin4_high_i(8'hea), .pg_raw_i(pg),
      .ext_enable_pin_3_i(pin3), .ext_enable_pin_4_i(pin4), .linear_pin_ctrl_o(lc), .buck_pin_ctrl_o(bc),
      .linear_pin_en_o(le), .buck_pin_en_o(be));
   task automatic summarize();
      if (errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [9:0] got, exp);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [7:0] a, e);
      logic [7:0] q;
      host.xfer(1'b0, a, 8'h00, q);
      chk({2'b00, q}, {2'b00, e});
   endtask
   task automatic wr(input logic [7:0] a, d);
      logic [7:0] q;
      host.xfer(1'b1, a, d, q);
   endtask
   // hang guard, far above the 63 cycles needed
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 2000) begin
         errors++;
         summarize();
      end
   end
   initial begin
      repeat (16) @(posedge clock_i);
      #1 rst_b_i = 1'b1;
      repeat (2) @(posedge clock_i);
      #1;
      rd(8'h34, 8'h3f);
      rd(8'h35, 8'ha5);
      rd(8'h36, 8'h2a);
      rd(8'h37, 8'h69);
      rd(8'h38, 8'h2c);
      rd(8'h40, 8'h00);
      wr(8'h37, 8'hff);
      rd(8'h37, 8'h69);
      wr(8'h38, 8'hff);
      rd(8'h38, 8'h2c);
      wr(8'h36, 8'hff);
      rd(8'h36, 8'h3f);
      wr(8'h34, 8'h00);
      chk({4'h0, bc, lc[9:8]}, 10'h03f);
      wr(8'h36, 8'h00);
      wr(8'h34, 8'h15);
      chk({4'h0, bc, lc[9:8]}, 10'h015);
      wr(8'h35, 8'h5a);
      chk({2'b00, lc[7:0]}, 10'h05a);
      chk(le, 10'h000);
      chk({6'h00, be}, 10'h000);
      pin3 = 1'b1;
      pin4 = 1'b1;
      pg = '0;
      repeat (3) @(posedge clock_i);
      #1;
      chk(le, 10'h15a);
      chk({6'h00, be}, 10'h005);
      wr(8'h36, 8'h3c);
      chk({6'h00, be}, 10'h00f);
      rd(8'h37, 8'h00);
      otp = 8'hc3;
      rst_b_i = 1'b0;
      repeat (2) @(posedge clock_i);
      #1 rst_b_i = 1'b1;
      rd(8'h35, 8'hc3);
      rd(8'h36, 8'h2a);
      summarize();
   end
endmodule // tb_pin_map_regs
`default_nettype wire
